/* verilog/ssf_consts.vh */
// constants of the serial status flag block
// How it works
// - tx complete high when buffer empty, line quiet
// - armed tx complete cleared by data, enable, break
// - rx full sets when character enters buffer
// - overrun pending drops characters, rx full stays
// - armed rx full cleared by data read
// - idle flag after one character of high line
// - idle select low counts from start bit
// - idle select high counts after stop bit
// - armed idle flag cleared by data read
// - idle flag rearms only after new character
// - overrun sets when unread buffer meets new character
// - armed overrun cleared by data read
// - seven start samples, three per later bit
// - noise flag loads with rx full
// - noise flag cleared by status then data read
// - framing error loads with rx full, stop zero
// - armed framing error cleared by data read
// - parity error loads with rx full when enabled
// - parity error cleared by status then data read
// - status register read only, writes ignored
// - tx empty sets on shifter load, cleared armed
`ifndef SSF_CONSTS_VH
`define SSF_CONSTS_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define SSF_OFS_STATUS   12'h000
`define SSF_OFS_DATA     12'h004
`define SSF_OFS_CTRL     12'h008
`define SSF_OFS_BAUD     12'h00c
// ---------------------------------------------------------------
// status bit positions
// ---------------------------------------------------------------
`define SSF_BIT_TX_BUFFER_EMPTY_FLAG     7
`define SSF_BIT_TC       6
`define SSF_BIT_RX_FULL_FLAG     5
`define SSF_BIT_IDLE     4
`define SSF_BIT_OR       3
`define SSF_BIT_NF       2
`define SSF_BIT_FE       1
`define SSF_BIT_PF       0
// ---------------------------------------------------------------
// control bit positions
// ---------------------------------------------------------------
`define SSF_CTL_PE       0
`define SSF_CTL_PODD     1
`define SSF_CTL_NINE     2
`define SSF_CTL_ILT      3
`define SSF_CTL_TXON     4
`define SSF_CTL_BRK      5
// ---------------------------------------------------------------
// reset values and timing counts
// ---------------------------------------------------------------
`define SSF_DIV_W        13
`define SSF_RST_CTRL     6'h00
`define SSF_RST_BAUD     13'h0001
`define SSF_START_FIRST  4'h4
`define SSF_START_LAST   4'ha
`define SSF_BIT_FIRST    4'h7
`define SSF_BIT_LAST     4'h9
`define SSF_SUB_LAST     4'hf
`define SSF_START_SMP    3'h7
`define SSF_BIT_SMP      3'h3
`define SSF_DATA_SHORT   4'h8
`define SSF_DATA_LONG    4'h9
`define SSF_CHAR_SHORT   4'ha
`define SSF_CHAR_LONG    4'hb
`endif

/* verilog/ssf_status.v */
// serial port with status flags, apb slave, tx and rx engines
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ssf_consts.vh"
module ssf_status (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        rxd,
  output reg         txd
);

  // ---------------------------------------------------------------
  // state declarations
  // ---------------------------------------------------------------
  localparam RX_IDLE  = 2'h0;  // waiting for a start bit
  localparam RX_START = 2'h1;  // qualifying the start bit
  localparam RX_BITS  = 2'h2;  // data, parity and stop bits

  reg  [5:0]  ctrl;            // control bits
  reg  [12:0] baud;            // 16x tick divisor, 0 stops clocks
  reg  [12:0] bcnt;            // divider count
  reg  [7:0]  arm;             // flags seen by the last status read, nf and pf armed by any
  reg         tx_buffer_empty_flag;            // tx buffer empty
  reg         tc;              // tx complete
  reg         rx_full_flag;            // rx buffer full
  reg         idle_f;          // idle line seen
  reg         orf;             // overrun
  reg         nf;              // noise
  reg         fe;              // framing error
  reg         pf;              // parity error
  reg  [8:0]  tx_buf;          // tx holding buffer
  reg  [10:0] tx_sh;           // tx shifter, lsb first
  reg  [3:0]  tx_left;         // bits still to send
  reg  [3:0]  tx_sub;          // tx 16x phase
  reg         tx_busy;         // a frame is on the line
  reg         pre_pend;        // preamble queued
  reg         brk_pend;        // break queued
  reg         rx_s1;           // synchroniser stage one
  reg         rx_in;           // synchronised line
  reg  [1:0]  rx_st;           // receiver state
  reg  [3:0]  rsub;            // rx 16x phase
  reg  [2:0]  ones;            // high samples in this bit
  reg  [3:0]  ridx;            // bit index after start
  reg  [8:0]  rsh;             // rx data shifter
  reg         rnoise;          // noise seen in this frame
  reg  [8:0]  rx_buf;          // rx data buffer
  reg  [3:0]  icnt;            // idle bit times counted
  reg         iskip;           // skip the stop bit period
  reg         iarm;            // idle flag may set
  reg  [31:0] rd_mux;          // read data before the flop

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire acc      = psel & penable;
  wire done     = acc & pready;
  wire wr_done  = done & pwrite;
  wire rd_done  = done & ~pwrite;
  wire hit_st   = (paddr == `SSF_OFS_STATUS);
  wire hit_dat  = (paddr == `SSF_OFS_DATA);
  wire hit_ctl  = (paddr == `SSF_OFS_CTRL);
  wire hit_bd   = (paddr == `SSF_OFS_BAUD);
  wire mapped   = hit_st | hit_dat | hit_ctl | hit_bd;
  wire st_rd    = rd_done & hit_st;
  wire dat_rd   = rd_done & hit_dat;
  wire dat_wr   = wr_done & hit_dat & pstrb[0];
  wire ctl_wr   = wr_done & hit_ctl & pstrb[0];
  wire bd_wr    = wr_done & hit_bd & pstrb[0];
  wire txon_up  = ctl_wr & pwdata[`SSF_CTL_TXON] & ~ctrl[`SSF_CTL_TXON];
  wire brk_wr1  = ctl_wr & pwdata[`SSF_CTL_BRK];
  wire nine     = ctrl[`SSF_CTL_NINE];
  wire podd     = ctrl[`SSF_CTL_PODD];
  wire pen      = ctrl[`SSF_CTL_PE];
  wire [7:0] status = {tx_buffer_empty_flag, tc, rx_full_flag, idle_f, orf, nf, fe, pf};

  // read mux, status writes fall through and change nothing
  always @* begin
    rd_mux = 32'h0000_0000;
    if (hit_st) begin
      rd_mux = {24'h00_0000, status};
    end else if (hit_dat) begin
      rd_mux = {23'h00_0000, rx_buf};
    end else if (hit_ctl) begin
      rd_mux = {26'h000_0000, ctrl};
    end else if (hit_bd) begin
      rd_mux = {19'h0_0000, baud};
    end
  end

  // one wait state keeps prdata and pready straight from flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (acc & ~pready) begin
      pready  <= 1'b1;
      pslverr <= ~mapped;
      prdata  <= rd_mux;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // control and divisor registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `SSF_RST_CTRL;
      baud <= `SSF_RST_BAUD;
    end else begin
      if (ctl_wr) begin
        ctrl <= pwdata[5:0];
      end
      if (bd_wr) begin
        baud <= pwdata[12:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // clear sequence arming
  // ---------------------------------------------------------------
  // prdata is what software saw, so a flag other than nf and pf raised after it
  // is not armed and survives the data access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm <= 8'h00;
    end else if (st_rd) begin
      arm <= prdata[7:0];
      arm[`SSF_BIT_NF] <= 1'b1;
      arm[`SSF_BIT_PF] <= 1'b1;
    end else begin
      if (dat_rd) begin
        arm[5:0] <= 6'h00;
      end
      if (dat_wr) begin
        arm[7] <= 1'b0;
      end
      if (dat_wr | txon_up | brk_wr1) begin
        arm[6] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // 16x tick divider
  // ---------------------------------------------------------------
  wire tick = (bcnt == 13'h0000) & (baud != 13'h0000);

  // down counter, a pulse each baud cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt <= 13'h0000;
    end else if (bcnt == 13'h0000) begin
      bcnt <= (baud == 13'h0000) ? 13'h0000 : baud - 13'h0001;
    end else begin
      bcnt <= bcnt - 13'h0001;
    end
  end

  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  wire tx_bit   = tick & (tx_sub == `SSF_SUB_LAST);
  wire [3:0] tx_len = nine ? `SSF_CHAR_LONG : `SSF_CHAR_SHORT;
  wire par9     = (^tx_buf[7:0]) ^ podd;
  wire par8     = (^tx_buf[6:0]) ^ podd;
  // top data bit carries parity when it is enabled
  wire [9:0] tx_word = nine ?
                  {1'b1, pen ? par9 : tx_buf[8], tx_buf[7:0]} :
                  {2'b11, pen ? par8 : tx_buf[7], tx_buf[6:0]};
  wire tx_free  = ~tx_busy | (tx_left == 4'h0);
  wire go_pre   = tx_bit & tx_free & pre_pend;
  wire go_brk   = tx_bit & tx_free & ~pre_pend & brk_pend;
  wire tx_load  = tx_bit & tx_free & ~pre_pend & ~brk_pend &
                  ~tx_buffer_empty_flag & ctrl[`SSF_CTL_TXON];
  wire tx_quiet = tx_buffer_empty_flag & ~tx_busy & ~pre_pend & ~brk_pend;
  wire tc_clr   = arm[`SSF_BIT_TC] & (dat_wr | txon_up | brk_wr1);

  // tx phase counter runs free on the 16x tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sub <= 4'h0;
    end else if (tick) begin
      tx_sub <= tx_sub + 4'h1;
    end
  end

  // frame shifter, preamble first, then break, then data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh    <= 11'h7ff;
      tx_left  <= 4'h0;
      tx_busy  <= 1'b0;
      txd      <= 1'b1;
      pre_pend <= 1'b0;
      brk_pend <= 1'b0;
    end else begin
      if (txon_up) begin
        pre_pend <= 1'b1;
      end else if (go_pre) begin
        pre_pend <= 1'b0;
      end
      if (brk_wr1) begin
        brk_pend <= 1'b1;
      end else if (go_brk) begin
        brk_pend <= 1'b0;
      end
      if (go_pre | go_brk | tx_load) begin
        tx_busy <= 1'b1;
        tx_left <= tx_len - 4'h1;
        if (go_pre) begin
          txd   <= 1'b1;  // idle character, all ones
          tx_sh <= 11'h7ff;
        end else if (go_brk) begin
          txd   <= 1'b0;  // break character, all zeros
          tx_sh <= 11'h000;
        end else begin
          txd   <= 1'b0;  // start bit
          tx_sh <= {1'b1, tx_word};
        end
      end else if (tx_bit & tx_busy) begin
        if (tx_left == 4'h0) begin
          tx_busy <= 1'b0;
          txd     <= 1'b1;
        end else begin
          txd     <= tx_sh[0];
          tx_sh   <= {1'b1, tx_sh[10:1]};
          tx_left <= tx_left - 4'h1;
        end
      end
    end
  end

  // tx buffer takes every data write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf <= 9'h000;
    end else if (dat_wr) begin
      tx_buf <= pwdata[8:0];
    end
  end

  // ---------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------
  wire [2:0] ones_n = ones + {2'b00, rx_in};
  wire [3:0] nbits  = nine ? `SSF_DATA_LONG : `SSF_DATA_SHORT;
  wire [3:0] clen   = nine ? `SSF_CHAR_LONG : `SSF_CHAR_SHORT;
  wire st_win = (rsub >= `SSF_START_FIRST) & (rsub <= `SSF_START_LAST);
  wire bt_win = (rsub >= `SSF_BIT_FIRST) & (rsub <= `SSF_BIT_LAST);
  wire st_end = tick & (rx_st == RX_START) & (rsub == `SSF_START_LAST);
  wire bt_end = tick & (rx_st == RX_BITS) & (rsub == `SSF_BIT_LAST);
  wire bitv   = (ones_n >= 3'h2);  // majority of three
  wire bt_nz  = (ones_n != 3'h0) & (ones_n != `SSF_BIT_SMP);
  wire st_nz  = (ones_n != 3'h0) & (ones_n != `SSF_START_SMP);
  wire fin    = bt_end & (ridx == nbits);
  wire [8:0] rdat = nine ? rsh : {1'b0, rsh[8:1]};
  wire new_nf = rnoise | bt_nz;
  wire new_fe = ~bitv;
  wire new_pf = pen & ((^rdat) != podd);
  wire rx_load = fin & ~orf & ~rx_full_flag;
  wire rx_over = fin & ~orf & rx_full_flag;
  wire wrap   = tick & (rsub == `SSF_SUB_LAST);
  wire idle_hit = iarm & (icnt == clen);

  // two flops before the line is looked at
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1 <= 1'b1;
      rx_in <= 1'b1;
    end else begin
      rx_s1 <= rxd;
      rx_in <= rx_s1;
    end
  end

  // frame sequencer with sample voting
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st  <= RX_IDLE;
      rsub   <= 4'h0;
      ones   <= 3'h0;
      ridx   <= 4'h0;
      rsh    <= 9'h000;
      rnoise <= 1'b0;
    end else if (tick) begin
      rsub <= rsub + 4'h1;
      case (rx_st)
        RX_IDLE: begin
          if (!rx_in) begin
            rx_st  <= RX_START;
            rsub   <= 4'h1;
            ones   <= 3'h0;
            rnoise <= 1'b0;
          end
        end
        RX_START: begin
          if (st_win) begin
            ones <= ones_n;
          end
          if (st_end) begin
            ones   <= 3'h0;
            ridx   <= 4'h0;
            rnoise <= st_nz;
            // a high majority was only a glitch
            rx_st  <= (ones_n >= 3'h4) ? RX_IDLE : RX_BITS;
          end
        end
        RX_BITS: begin
          if (bt_win) begin
            ones <= ones_n;
          end
          if (bt_end) begin
            ones   <= 3'h0;
            rnoise <= new_nf;
            ridx   <= ridx + 4'h1;
            if (ridx != nbits) begin
              rsh <= {bitv, rsh[8:1]};
            end else begin
              rx_st <= RX_IDLE;
            end
          end
        end
        default: begin
          rx_st <= RX_IDLE;
        end
      endcase
    end
  end

  // idle bit time counter, saturating at one character
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      icnt  <= 4'h0;
      iskip <= 1'b0;
    end else if (tick & (rx_st == RX_IDLE) & ~rx_in) begin
      icnt  <= 4'h0;
      iskip <= 1'b0;
    end else if (fin & ctrl[`SSF_CTL_ILT]) begin
      icnt  <= 4'h0;
      iskip <= 1'b1;
    end else if (bt_end & (ridx != nbits)) begin
      if (ctrl[`SSF_CTL_ILT] | ~bitv) begin
        icnt <= 4'h0;
      end else if (icnt != clen) begin
        icnt <= icnt + 4'h1;
      end
    end else if (wrap & (rx_st == RX_IDLE) & rx_in) begin
      // the stop bit period ends here; it counts only when low select
      if (iskip) begin
        iskip <= 1'b0;
      end else if (icnt != clen) begin
        icnt <= icnt + 4'h1;
      end
    end
  end

  // rx buffer and idle arming
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf <= 9'h000;
      iarm   <= 1'b0;
    end else begin
      if (rx_load) begin
        rx_buf <= rdat;
      end
      if (rx_load) begin
        iarm <= 1'b1;
      end else if (idle_hit) begin
        iarm <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // status flags, a set in the clearing cycle wins, except tc where the clear wins
  // ---------------------------------------------------------------
  wire clr_rd = dat_rd;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buffer_empty_flag   <= 1'b1;
      tc     <= 1'b1;
      rx_full_flag   <= 1'b0;
      idle_f <= 1'b0;
      orf    <= 1'b0;
      nf     <= 1'b0;
      fe     <= 1'b0;
      pf     <= 1'b0;
    end else begin
      tx_buffer_empty_flag <= tx_load | (tx_buffer_empty_flag & ~(dat_wr & arm[`SSF_BIT_TX_BUFFER_EMPTY_FLAG]));
      tc   <= tx_quiet & ~tc_clr;
      rx_full_flag <= rx_load |
              (rx_full_flag & ~(clr_rd & arm[`SSF_BIT_RX_FULL_FLAG]));
      idle_f <= idle_hit |
                (idle_f & ~(clr_rd & arm[`SSF_BIT_IDLE]));
      orf  <= rx_over |
              (orf & ~(clr_rd & arm[`SSF_BIT_OR]));
      nf   <= (rx_load & new_nf) |
              (nf & ~(clr_rd & arm[`SSF_BIT_NF]));
      fe   <= (rx_load & new_fe) |
              (fe & ~(clr_rd & arm[`SSF_BIT_FE]));
      pf   <= (rx_load & new_pf) |
              (pf & ~(clr_rd & arm[`SSF_BIT_PF]));
    end
  end

endmodule
`default_nettype wire

/* tb/ssf_status_properties.sv */
// concurrent checks on the ports of the serial status block
`timescale 1ns/1ps
`default_nettype none
module ssf_status_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rxd,
  input wire logic        txd
);
  // ----------------------------
  // clocking and helpers
  // ----------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a status read completes at this edge
  wire logic rd_st = pready && !pwrite && paddr == 12'h000;
  // ----------------------------
  // bus handshake
  // ----------------------------
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready not after one wait state");
  a_ready_cause: assert property (
    pready |-> psel && penable && $past(psel && penable))
    else $error("pready without access phase");
  a_err_map: assert property (pready |->
    pslverr == (paddr[1:0] != 2'h0 || paddr[11:4] != 8'h00))
    else $error("pslverr does not follow the map");
  a_rdata_hold: assert property (!(psel && penable) |=> $stable(prdata))
    else $error("prdata moved outside an access");
  // ----------------------------
  // status contents and line
  // ----------------------------
  a_status_upper: assert property (
    rd_st |-> prdata[31:8] == 24'h0)
    else $error("status upper bits not zero");
  a_err_full: assert property (
    rd_st && (|prdata[2:0]) |-> prdata[5])
    else $error("error flag without rx full");
  a_tc_busy: assert property (
    rd_st && !$past(txd) && !$past(txd, 2) |-> !prdata[6])
    else $error("tx complete while line driven low");
  a_txd_reset: assert property ($rose(presetn) |-> txd)
    else $error("txd not idle after reset");
endmodule
bind ssf_status ssf_status_properties u_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .rxd(rxd),
  .txd(txd)
);
`default_nettype wire

/* tb/ssf_serial_node.sv */
// remote serial node: drives the receive line, listens on txd
`timescale 1ns/1ps
`default_nettype none
module ssf_serial_node #(
  parameter int BIT_CYC = 16 // pclk cycles per bit at baud 1
) (
  input  wire logic pclk,
  output var  logic rxd,
  input  wire logic txd
);
  initial rxd = 1'b1; // line idles high
  // ----------------------------
  // one frame, lsb first; bad stop or one-cycle glitch on demand
  // ----------------------------
  task automatic send(input logic [8:0] d, input int nb,
                      input logic stp, input logic gl);
    logic [11:0] f;
    int          i;
    int          k;
    f = {2'b11, d, 1'b0};
    f[nb + 1] = stp;
    for (i = 0; i < nb + 2; i++) begin
      // a low stop bit gives up one cycle to the closing high edge,
      // so its tail reads as a rejected glitch, not a fresh start
      for (k = 0; k < BIT_CYC - ((i == nb + 1 && !stp) ? 1 : 0); k++) begin
        @(posedge pclk);
        // glitch lands on the middle vote sample of data bit 0
        rxd <= f[i] ^ (gl && i == 1 && k == 8);
      end
    end
    @(posedge pclk);
    rxd <= 1'b1;
  endtask
  // ----------------------------
  // take eight bits from txd; bounded wait for the start bit
  // ----------------------------
  task automatic recv(output logic [7:0] d);
    int i;
    for (i = 0; i < 4000 && txd; i++) @(posedge pclk);
    repeat (BIT_CYC + BIT_CYC / 2) @(posedge pclk);
    for (i = 0; i < 8; i++) begin
      d[i] = txd;
      repeat (BIT_CYC) @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

/* tb/test_serial_status_flag_logic.sv */
// self-checking bench for the serial status flag block
`timescale 1ns/1ps
`default_nettype none
module test_serial_status_flag_logic;
  typedef struct packed {
    logic [5:0] ctl;  // control value
    logic [8:0] d;    // bits sent
    logic       nine; // nine data bits
    logic       stp;  // stop bit level
    logic       gl;   // inject glitch
    logic [7:0] ea;   // status after frame
    logic [8:0] m;    // data compare mask
    logic [7:0] eb;   // status after data read
  } ssf_row_t;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         rxd;
  wire         txd;
  int          num_errors = 0;
  int          checks_done = 0;
  logic [31:0] rd;     // last read data
  logic        er;     // last error response
  logic [7:0]  tx_got; // byte seen on txd
  int          r;
  // plain cases: ctl d nine stp gl ea m eb
  ssf_row_t rows [9] = '{
    '{6'h00, 9'h0a5, 1'b0, 1'b1, 1'b0, 8'he0, 9'h0ff, 8'hc0},
    '{6'h00, 9'h03c, 1'b0, 1'b0, 1'b0, 8'he2, 9'h0ff, 8'hc0},
    '{6'h00, 9'h0f0, 1'b0, 1'b1, 1'b1, 8'he4, 9'h0ff, 8'hc0},
    '{6'h01, 9'h083, 1'b0, 1'b1, 1'b0, 8'he1, 9'h07f, 8'hc0},
    '{6'h01, 9'h003, 1'b0, 1'b1, 1'b0, 8'he0, 9'h07f, 8'hc0},
    '{6'h03, 9'h003, 1'b0, 1'b1, 1'b0, 8'he1, 9'h07f, 8'hc0},
    '{6'h04, 9'h1a5, 1'b1, 1'b1, 1'b0, 8'he0, 9'h1ff, 8'hc0},
    '{6'h00, 9'h0ff, 1'b0, 1'b1, 1'b0, 8'he0, 9'h0ff, 8'hd0},
    '{6'h08, 9'h0ff, 1'b0, 1'b1, 1'b0, 8'he0, 9'h0ff, 8'hc0}};
  always #25 pclk = ~pclk; // 20 MHz
  ssf_status dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd));
  ssf_serial_node node (.pclk(pclk), .rxd(rxd), .txd(txd));
  // ----------------------------
  // report, compare, bus tasks
  // ----------------------------
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input logic [31:0] m);
    checks_done++;
    if ((got & m) !== (exp & m)) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got & m, exp & m);
    end
  endtask
  // one transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic rd_cmp(input logic [11:0] a, input logic [31:0] e,
                        input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    cmp(rd, e, m);
  endtask
  // poll status until tx complete shows; bounded
  task automatic wait_tc();
    int i;
    for (i = 0; i < 100; i++) begin
      apb(1'b0, 12'h000, 32'h0);
      if (rd[6] === 1'b1) break;
    end
    if (i == 100) begin
      num_errors++;
      conclude();
    end
  endtask
  // ----------------------------
  // main sequence
  // ----------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd_cmp(12'h000, 32'hc0, ALL);
    apb(1'b1, 12'h000, 32'hff);
    rd_cmp(12'h000, 32'hc0, ALL);
    apb(1'b1, 12'h010, 32'h0);
    cmp({31'h0, er}, 32'h1, ALL);
    for (r = 0; r < 9; r++) begin
      apb(1'b1, 12'h008, {26'h0, rows[r].ctl});
      node.send(rows[r].d, rows[r].nine ? 9 : 8, rows[r].stp, rows[r].gl);
      rd_cmp(12'h000, {24'h0, rows[r].ea}, ALL);
      rd_cmp(12'h004, {23'h0, rows[r].d}, {23'h0, rows[r].m});
      repeat (40) @(posedge pclk);
      rd_cmp(12'h000, {24'h0, rows[r].eb}, ALL);
      repeat (200) @(posedge pclk);
      rd_cmp(12'h000, 32'hd0, ALL);
      apb(1'b0, 12'h004, 32'h0);
      repeat (200) @(posedge pclk);
      rd_cmp(12'h000, 32'hc0, ALL);
    end
    // overrun: third frame is noisy and must leave no trace
    apb(1'b1, 12'h008, 32'h0);
    node.send(9'h011, 8, 1'b1, 1'b0);
    node.send(9'h022, 8, 1'b1, 1'b0);
    node.send(9'h033, 8, 1'b1, 1'b1);
    rd_cmp(12'h000, 32'he8, ALL);
    rd_cmp(12'h004, 32'h11, 32'hff);
    rd_cmp(12'h000, 32'hc0, 32'hef);
    // frame lands between status and data read
    node.send(9'h055, 8, 1'b1, 1'b1);
    apb(1'b0, 12'h004, 32'h0);
    rd_cmp(12'h000, 32'he0, 32'hef);
    rd_cmp(12'h004, 32'h55, 32'hff);
    // transmit: preamble, data, break
    apb(1'b1, 12'h008, 32'h10);
    repeat (20) @(posedge pclk);
    rd_cmp(12'h000, 32'h80, 32'hc0);
    wait_tc();
    fork
      node.recv(tx_got);
      apb(1'b1, 12'h004, 32'h5a);
    join
    cmp({24'h0, tx_got}, 32'h5a, ALL);
    rd_cmp(12'h000, 32'h80, 32'hc0);
    wait_tc();
    apb(1'b1, 12'h008, 32'h30);
    node.recv(tx_got);
    cmp({24'h0, tx_got}, 32'h0, ALL);
    rd_cmp(12'h000, 32'h80, 32'hc0);
    wait_tc();
    conclude();
  end
endmodule
`default_nettype wire
